// File: hdl/dotc_trigger_ctrl.sv
// Shared output trigger controller with AXI4-Lite register slave
`timescale 1ns/1ps
`include "dotc_consts.svh"
module dotc_trigger_ctrl (
   input  wire logic        core_clk_i,
   input  wire logic        srst_i,
   input  wire logic        sixteen_ch_i,
   input  wire logic [7:0]  ttl_trig_n_i,
   input  wire logic        term_trig_i,
   input  wire logic [7:0]  s_awaddr_i,
   input  wire logic        s_awvalid_i,
   output logic             s_awready_o,
   input  wire logic [31:0] s_wdata_i,
   input  wire logic [3:0]  s_wstrb_i,
   input  wire logic        s_wvalid_i,
   output logic             s_wready_o,
   output logic [1:0]       s_bresp_o,
   output logic             s_bvalid_o,
   input  wire logic        s_bready_i,
   input  wire logic [7:0]  s_araddr_i,
   input  wire logic        s_arvalid_i,
   output logic             s_arready_o,
   output logic [31:0]      s_rdata_o,
   output logic [1:0]       s_rresp_o,
   output logic             s_rvalid_o,
   input  wire logic        s_rready_i,
   output logic [15:0]      relay_close_control_o,
   output logic             apply_pulse_o,
   output logic             waiting_o,
   output logic             irq_o
);
   import dotc_pkg::*;

   // Channel index check against build size
   function automatic logic idx_ok(input logic [31:0] idx, input logic big);
      idx_ok = (idx >= 32'h1) && (idx <= (big ? 32'h10 : 32'h8));
   endfunction

   dotc_origin_e      origin_q;
   logic [2:0]        ttl_sel_q;
   dotc_state_e       state_q;
   dotc_setpt_s       pend_q [0:15];
   logic [15:0]       pend_vld_q;
   dotc_chout_s       out_q  [0:15];
   logic [4:0]        pidx_q;
   logic [4:0]        oidx_q;
   logic [2:0]        irq_st_q;
   logic [2:0]        irq_msk_q;
   logic              opc_q;
   logic [7:0]        ttl_s1_q, ttl_s2_q, ttl_s3_q;
   logic [2:0]        term_s_q;
   logic              aw_hold_q, w_hold_q;
   logic [7:0]        awaddr_q;
   logic [31:0]       wdata_q;
   logic              fire;
   logic              evt;
   logic              wr_go;
   logic [2:0]        irq_set;
   logic              err_ev;
   logic              pidx_wr, pval_wr, oidx_wr, relay_wr, cmd_wr;
   logic              arm_cmd, abort_cmd, sw_cmd, opc_cmd;

   // Three-stage synchronisers for backplane lines and terminal input
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         ttl_s1_q <= 8'hFF;
         ttl_s2_q <= 8'hFF;
         ttl_s3_q <= 8'hFF;
         term_s_q <= 3'h0;
      end else begin
         ttl_s1_q <= ttl_trig_n_i;
         ttl_s2_q <= ttl_s1_q;
         ttl_s3_q <= ttl_s2_q;
         term_s_q <= {term_s_q[1:0], term_trig_i};
      end
   end

   // Write channel capture: address and data in either order
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         aw_hold_q <= 1'b0;
         w_hold_q  <= 1'b0;
         awaddr_q  <= 8'h00;
         wdata_q   <= 32'h0;
      end else begin
         if (s_awvalid_i && s_awready_o) begin
            aw_hold_q <= 1'b1;
            awaddr_q  <= s_awaddr_i;
         end else if (wr_go) begin
            aw_hold_q <= 1'b0;
         end
         if (s_wvalid_i && s_wready_o) begin
            w_hold_q <= 1'b1;
            wdata_q  <= s_wdata_i;
         end else if (wr_go) begin
            w_hold_q <= 1'b0;
         end
      end
   end

   // Ready flags and write response
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         s_awready_o <= 1'b0;
         s_wready_o  <= 1'b0;
         s_bvalid_o  <= 1'b0;
      end else begin
         s_awready_o <= !aw_hold_q && !(s_awvalid_i && s_awready_o) && !s_bvalid_o;
         s_wready_o  <= !w_hold_q && !(s_wvalid_i && s_wready_o) && !s_bvalid_o;
         if (wr_go)
            s_bvalid_o <= 1'b1;
         else if (s_bready_i)
            s_bvalid_o <= 1'b0;
      end
   end
   assign s_bresp_o = 2'h0;

   // Write decode; the write word only applies once both halves are held
   assign wr_go     = aw_hold_q && w_hold_q && !s_bvalid_o;
   assign cmd_wr    = wr_go && (awaddr_q == `DOTC_ADDR_CMD);
   assign pidx_wr   = wr_go && (awaddr_q == `DOTC_ADDR_PIDX);
   assign pval_wr   = wr_go && (awaddr_q == `DOTC_ADDR_PVAL);
   assign oidx_wr   = wr_go && (awaddr_q == `DOTC_ADDR_OIDX);
   assign relay_wr  = wr_go && (awaddr_q == `DOTC_ADDR_RELAY);
   assign arm_cmd   = cmd_wr && wdata_q[`DOTC_CMD_ARM];
   assign abort_cmd = cmd_wr && wdata_q[`DOTC_CMD_ABORT];
   assign sw_cmd    = cmd_wr && wdata_q[`DOTC_CMD_SWTRIG];
   assign opc_cmd   = cmd_wr && wdata_q[`DOTC_CMD_OPC];

   // Origin and backplane line selection, held until changed or reset
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         origin_q  <= dotc_origin_e'(`DOTC_RST_ORIGIN);
         ttl_sel_q <= 3'h0;
      end else if (wr_go && awaddr_q == `DOTC_ADDR_CTRL) begin
         origin_q  <= dotc_origin_e'(wdata_q[1:0]);
         ttl_sel_q <= wdata_q[6:4];
      end
   end

   // Event from the chosen origin, falling edge on backplane, rising on terminal
   always_comb begin
      case (origin_q)
         DOTC_ORG_BACKPLANE: evt = ttl_s3_q[ttl_sel_q] && !ttl_s2_q[ttl_sel_q];
         DOTC_ORG_SOFTWARE:  evt = sw_cmd;
         DOTC_ORG_IMMEDIATE: evt = 1'b1;
         DOTC_ORG_TERMINAL:  evt = term_s_q[1] && !term_s_q[2];
         default:            evt = 1'b0;
      endcase
   end
   assign fire = (state_q == DOTC_ST_WAIT) && evt && !abort_cmd;

   // Shared trigger state: arm, fire back to idle, abort
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         state_q <= DOTC_ST_IDLE;
      end else begin
         case (state_q)
            DOTC_ST_IDLE: if (arm_cmd && !abort_cmd) state_q <= DOTC_ST_WAIT;
            DOTC_ST_WAIT: if (abort_cmd || fire) state_q <= DOTC_ST_IDLE;
            default:      state_q <= DOTC_ST_IDLE;
         endcase
      end
   end

   // Index registers for pending and output readback
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         pidx_q <= 5'h1;
         oidx_q <= 5'h1;
      end else begin
         if (pidx_wr && idx_ok(wdata_q, sixteen_ch_i))
            pidx_q <= wdata_q[4:0];
         if (oidx_wr && idx_ok(wdata_q, sixteen_ch_i))
            oidx_q <= wdata_q[4:0];
      end
   end

   // Pending setpoints, refused while waiting, moved to outputs on fire
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         pend_vld_q <= 16'h0;
         for (int i = 0; i < `DOTC_NCH; i++) begin
            pend_q[i] <= '0;
            out_q[i]  <= '0;
         end
      end else begin
         if (pval_wr && state_q == DOTC_ST_IDLE) begin
            pend_q[pidx_q[3:0] - 4'h1] <= '{value: {1'b0, wdata_q[30:0]},
                                            is_current: wdata_q[31]};
            pend_vld_q[pidx_q[3:0] - 4'h1] <= 1'b1;
         end
         for (int i = 0; i < `DOTC_NCH; i++) begin
            if (fire && pend_vld_q[i]) begin
               out_q[i].value      <= pend_q[i].value;
               out_q[i].is_current <= pend_q[i].is_current;
            end
            out_q[i].relay <= relay_close_control_o[i];
         end
         if (fire)
            pend_vld_q <= 16'h0;
      end
   end

   // Relay control, written at any time regardless of trigger state
   always_ff @(posedge core_clk_i) begin
      if (srst_i)
         relay_close_control_o <= 16'h0;
      else if (relay_wr)
         relay_close_control_o <= wdata_q[15:0] & (sixteen_ch_i ? 16'hFFFF : 16'h00FF);
   end

   // Errors: bad index, or pending write while waiting
   assign err_ev = (pval_wr && state_q == DOTC_ST_WAIT)
                 || ((pidx_wr || oidx_wr) && !idx_ok(wdata_q, sixteen_ch_i));
   assign irq_set = {opc_cmd, err_ev, fire};

   // Completion flag: all commands complete in the cycle they are taken
   always_ff @(posedge core_clk_i) begin
      if (srst_i)
         opc_q <= 1'b0;
      else if (opc_cmd)
         opc_q <= 1'b1;
      else if (cmd_wr)
         opc_q <= 1'b0;
   end

   // Sticky interrupt status, write one to clear, set wins
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         irq_st_q  <= 3'h0;
         irq_msk_q <= 3'h0;
         irq_o     <= 1'b0;
      end else begin
         if (wr_go && awaddr_q == `DOTC_ADDR_IRQ_ST)
            irq_st_q <= (irq_st_q & ~wdata_q[2:0]) | irq_set;
         else
            irq_st_q <= irq_st_q | irq_set;
         if (wr_go && awaddr_q == `DOTC_ADDR_IRQ_MSK)
            irq_msk_q <= wdata_q[2:0];
         irq_o <= |(irq_st_q & irq_msk_q);
      end
   end

   // Output strobes for the converters
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         apply_pulse_o <= 1'b0;
         waiting_o     <= 1'b0;
      end else begin
         apply_pulse_o <= fire;
         // Tracks the trigger state register itself, so an immediate fire still shows armed
         waiting_o     <= (state_q == DOTC_ST_IDLE) ? (arm_cmd && !abort_cmd)
                                                    : (!fire && !abort_cmd);
      end
   end

   // Read channel, one cycle latency, unmapped reads zero with OKAY
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         s_arready_o <= 1'b0;
         s_rvalid_o  <= 1'b0;
         s_rdata_o   <= 32'h0;
      end else begin
         s_arready_o <= !s_rvalid_o && !(s_arvalid_i && s_arready_o);
         if (s_arvalid_i && s_arready_o) begin
            s_rvalid_o <= 1'b1;
            case (s_araddr_i)
               `DOTC_ADDR_CTRL:    s_rdata_o <= {25'h0, ttl_sel_q, 2'h0, origin_q};
               `DOTC_ADDR_STATUS:  s_rdata_o <= {29'h0, opc_q, 1'b0, state_q == DOTC_ST_WAIT};
               `DOTC_ADDR_IRQ_ST:  s_rdata_o <= {29'h0, irq_st_q};
               `DOTC_ADDR_IRQ_MSK: s_rdata_o <= {29'h0, irq_msk_q};
               `DOTC_ADDR_RELAY:   s_rdata_o <= {16'h0, relay_close_control_o};
               `DOTC_ADDR_PIDX:    s_rdata_o <= {27'h0, pidx_q};
               `DOTC_ADDR_PVAL:    s_rdata_o <= {pend_q[pidx_q[3:0] - 4'h1].is_current,
                                                 pend_q[pidx_q[3:0] - 4'h1].value[30:0]};
               `DOTC_ADDR_OIDX:    s_rdata_o <= {27'h0, oidx_q};
               `DOTC_ADDR_OVAL:    s_rdata_o <= {out_q[oidx_q[3:0] - 4'h1].is_current,
                                                 out_q[oidx_q[3:0] - 4'h1].value[30:0]};
               `DOTC_ADDR_CHCNT:   s_rdata_o <= sixteen_ch_i ? 32'h10 : 32'h8;
               default:            s_rdata_o <= 32'h0;
            endcase
         end else if (s_rready_i) begin
            s_rvalid_o <= 1'b0;
         end
      end
   end
   assign s_rresp_o = 2'h0;
endmodule

// File: hdl/dotc_consts.svh
// Register offsets, field positions, reset values and list of behaviours for trigger control
// Function
// - Host selects one of four trigger origins
// - Backplane origin uses one of eight low lines
// - Immediate origin arms then fires at once
// - Terminal origin fires from dedicated terminal input
// - Pending setpoint applied to output on trigger
// - Arm command moves idle into waiting state
// - One event updates all pending channels together
// - After firing the system returns to idle
// - New pending value leaves present output unchanged
// - Host may open a relay any time
// - Origin retained; reset selects software origin
// - Completion query answers one when all done
// - Common commands short, asterisk, space before parameter; not done here, commands are bits written to the command register
// - Channel index outside valid range gives error
// - Abort forces idle; later arm waits again
`ifndef DOTC_CONSTS_SVH
`define DOTC_CONSTS_SVH
`define DOTC_NCH          16
`define DOTC_ADDR_CTRL    8'h00
`define DOTC_ADDR_CMD     8'h04
`define DOTC_ADDR_STATUS  8'h08
`define DOTC_ADDR_IRQ_ST  8'h0C
`define DOTC_ADDR_IRQ_MSK 8'h10
`define DOTC_ADDR_RELAY   8'h14
`define DOTC_ADDR_PIDX    8'h18
`define DOTC_ADDR_PVAL    8'h1C
`define DOTC_ADDR_OIDX    8'h20
`define DOTC_ADDR_OVAL    8'h24
`define DOTC_ADDR_CHCNT   8'h28
`define DOTC_CMD_ARM      0
`define DOTC_CMD_ABORT    1
`define DOTC_CMD_SWTRIG   2
`define DOTC_CMD_OPC      3
`define DOTC_IRQ_FIRE     0
`define DOTC_IRQ_ERR      1
`define DOTC_IRQ_OPC      2
`define DOTC_RST_ORIGIN   2'h1
`endif

// File: hdl/dotc_pkg.sv
// Types for the output trigger controller
package dotc_pkg;
   typedef enum logic [1:0] {
      DOTC_ORG_BACKPLANE,
      DOTC_ORG_SOFTWARE,
      DOTC_ORG_IMMEDIATE,
      DOTC_ORG_TERMINAL
   } dotc_origin_e;
   typedef enum logic {
      DOTC_ST_IDLE,
      DOTC_ST_WAIT
   } dotc_state_e;
   typedef struct packed {
      logic [31:0] value;
      logic        is_current;
   } dotc_setpt_s;
   typedef struct packed {
      logic [31:0] value;
      logic        is_current;
      logic        relay;
   } dotc_chout_s;
endpackage

// File: tb/dotc_trigger_ctrl_chk.sv
// Port-level assertions for the output trigger controller
`timescale 1ns/1ps
module dotc_trigger_ctrl_chk (
   input wire logic        core_clk_i,
   input wire logic        srst_i,
   input wire logic        s_awvalid_i,
   input wire logic        s_awready_o,
   input wire logic        s_wvalid_i,
   input wire logic        s_wready_o,
   input wire logic [1:0]  s_bresp_o,
   input wire logic        s_bvalid_o,
   input wire logic        s_bready_i,
   input wire logic        s_arvalid_i,
   input wire logic        s_arready_o,
   input wire logic [31:0] s_rdata_o,
   input wire logic        s_rvalid_o,
   input wire logic        s_rready_i,
   input wire logic [15:0] relay_close_control_o,
   input wire logic        apply_pulse_o,
   input wire logic        waiting_o,
   input wire logic        irq_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (srst_i);
   // Trigger outcome, reset values and relay writes
   pulse_one_a: assert property (apply_pulse_o |=> !apply_pulse_o)
      else $error("apply pulse lasts more than one cycle");
   idle_after_a: assert property (apply_pulse_o |-> !waiting_o)
      else $error("still waiting after outputs applied");
   fire_armed_a: assert property (apply_pulse_o |-> $past(waiting_o))
      else $error("outputs applied without being armed");
   rst_out_a: assert property (disable iff (1'h0) srst_i |=> relay_close_control_o == 16'h0
      && !waiting_o && !irq_o && !apply_pulse_o && !s_bvalid_o && !s_rvalid_o)
      else $error("outputs not cleared by reset");
   relay_wr_a: assert property ($changed(relay_close_control_o) |-> s_bvalid_o)
      else $error("relay state moved without a write");
   // Register bus answers
   wr_answer_a: assert property (s_awvalid_i && s_awready_o && s_wvalid_i && s_wready_o
      |-> ##[1:2] s_bvalid_o) else $error("write response late");
   bresp_hold_a: assert property (s_bvalid_o && !s_bready_i |=> s_bvalid_o && s_bresp_o == 2'h0)
      else $error("write response dropped early");
   rd_answer_a: assert property (s_arvalid_i && s_arready_o |=> s_rvalid_o)
      else $error("read data late");
   rdata_hold_a: assert property (s_rvalid_o && !s_rready_i |=> s_rvalid_o && $stable(s_rdata_o))
      else $error("read data changed before taken");
endmodule

// File: tb/dotc_trig_src.sv
// Far-side model: backplane trigger lines and terminal trigger input
`timescale 1ns/1ps
module dotc_trig_src (
   input  wire logic       core_clk_i,
   output logic      [7:0] ttl_trig_n_o,
   output logic            term_trig_o
);
   // Backplane lines are pulled up, so released lines sit high
   initial ttl_trig_n_o = 8'hFF;
   initial term_trig_o = 1'h0;
   // Low pulse on one of eight lines, held for a chosen number of cycles
   task ttl_pulse(input int ln, input int hold);
      @(posedge core_clk_i) ttl_trig_n_o[ln[2:0]] <= 1'h0;
      repeat (hold) @(posedge core_clk_i);
      ttl_trig_n_o[ln[2:0]] <= 1'h1;
   endtask
   // High pulse on the terminal input
   task term_pulse(input int hold);
      @(posedge core_clk_i) term_trig_o <= 1'h1;
      repeat (hold) @(posedge core_clk_i);
      term_trig_o <= 1'h0;
   endtask
endmodule

// File: tb/dotc_trigger_ctrl_tb.sv
// Self-checking bench for the output trigger controller
`timescale 1ns/1ps
`include "dotc_consts.svh"
module dotc_trigger_ctrl_tb;
   import dotc_pkg::*;
   logic        core_clk_i = 1'h0, srst_i = 1'h1;
   logic [7:0]  awaddr = 8'h0, araddr = 8'h0, ttl_n;
   logic [31:0] wdata = 32'h0, rdata, v, v2;
   logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic        term, awready, wready, bvalid, arready, rvalid, apply, irq;
   logic [15:0] relay;
   logic [31:0] exp_q[$];
   int          n_errors = 0, n_checks = 0, cyc = 0, n_apply = 0, n_fires = 0;
   logic        sixteen = 1'h1;
   always #5 core_clk_i = ~core_clk_i;
   dotc_trigger_ctrl dotc_trigger_ctrl_inst (.core_clk_i(core_clk_i), .srst_i(srst_i),
      .sixteen_ch_i(sixteen), .ttl_trig_n_i(ttl_n), .term_trig_i(term), .s_awaddr_i(awaddr),
      .s_awvalid_i(awvalid), .s_awready_o(awready), .s_wdata_i(wdata), .s_wstrb_i(4'hF),
      .s_wvalid_i(wvalid), .s_wready_o(wready), .s_bresp_o(), .s_bvalid_o(bvalid),
      .s_bready_i(bready), .s_araddr_i(araddr), .s_arvalid_i(arvalid), .s_arready_o(arready),
      .s_rdata_o(rdata), .s_rresp_o(), .s_rvalid_o(rvalid), .s_rready_i(rready),
      .relay_close_control_o(relay), .apply_pulse_o(apply), .waiting_o(), .irq_o(irq));
   dotc_trig_src dotc_trig_src_inst (.core_clk_i(core_clk_i), .ttl_trig_n_o(ttl_n),
      .term_trig_o(term));
   task complete_run;
      $display("errors %0d checks %0d", n_errors, n_checks);
      if (n_errors == 0 && n_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Each read beat is compared with the oldest noted expectation
   always @(posedge core_clk_i) if (rvalid && rready) chk(rdata, exp_q.pop_front());
   // Apply pulses counted at the edge where they stand, idle ones included
   always @(posedge core_clk_i) if (apply) n_apply++;
   // Hang guard
   always @(posedge core_clk_i) if (++cyc == 20000) begin
      n_errors++;
      complete_run;
   end
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic ad, wd;
      ad = 1'h0; wd = 1'h0;
      @(posedge core_clk_i);
      awaddr <= a; wdata <= d; awvalid <= 1'h1; wvalid <= 1'h1; bready <= 1'h1;
      do begin
         @(posedge core_clk_i);
         if (awvalid && awready) begin ad = 1'h1; awvalid <= 1'h0; end
         if (wvalid && wready) begin wd = 1'h1; wvalid <= 1'h0; end
      end while (!(ad && wd && bvalid));
      bready <= 1'h0;
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      @(posedge core_clk_i);
      araddr <= a; arvalid <= 1'h1; rready <= 1'h1;
      do begin
         @(posedge core_clk_i);
         if (arvalid && arready) arvalid <= 1'h0;
      end while (!rvalid);
      rready <= 1'h0;
   endtask
   task wait_apply;
      int i;
      i = 0;
      n_fires++;
      while (n_apply < n_fires && i < 30) begin @(posedge core_clk_i); i++; end
      chk(n_apply, n_fires);
   endtask
   task pend(input logic [7:0] ch, input logic [31:0] d);
      wr(`DOTC_ADDR_PIDX, {24'h0, ch});
      wr(`DOTC_ADDR_PVAL, d);
   endtask
   task out_is(input logic [7:0] ch, input logic [31:0] e);
      wr(`DOTC_ADDR_OIDX, {24'h0, ch});
      rd(`DOTC_ADDR_OVAL, e);
   endtask
   // One load, arm and fire pass for a given origin; idle events come first
   task arm_fire(input logic [1:0] org, input int ln);
      v = $urandom;
      wr(`DOTC_ADDR_CTRL, {25'h0, ln[2:0], 2'h0, org});
      pend(8'h3, v);
      dotc_trig_src_inst.ttl_pulse(ln, 5);
      dotc_trig_src_inst.term_pulse(5);
      wr(`DOTC_ADDR_CMD, 32'h1);
      if (org == DOTC_ORG_BACKPLANE) begin
         dotc_trig_src_inst.ttl_pulse((ln + 1) % 8, 5);
         rd(`DOTC_ADDR_STATUS, 32'h1);
         dotc_trig_src_inst.ttl_pulse(ln, 2);
      end
      if (org == DOTC_ORG_SOFTWARE) wr(`DOTC_ADDR_CMD, 32'h4);
      if (org == DOTC_ORG_TERMINAL) dotc_trig_src_inst.term_pulse(1);
      wait_apply;
      out_is(8'h3, v);
      rd(`DOTC_ADDR_STATUS, 32'h0);
   endtask
   initial begin
      v = $urandom(32'hCA53);
      repeat (3) @(posedge core_clk_i);
      srst_i <= 1'h0;
      rd(`DOTC_ADDR_CTRL, {30'h0, `DOTC_RST_ORIGIN});
      rd(`DOTC_ADDR_CHCNT, `DOTC_NCH);
      // Relays closed, two channels loaded, then armed: the host sequence
      wr(`DOTC_ADDR_RELAY, 32'h3);
      chk({16'h0, relay}, 32'h3);
      v = $urandom & 32'h7FFFFFFF;
      v2 = $urandom | 32'h80000000;
      pend(8'h1, v);
      pend(8'h2, v2);
      wr(`DOTC_ADDR_CMD, 32'h1);
      rd(`DOTC_ADDR_STATUS, 32'h1);
      wr(`DOTC_ADDR_PVAL, 32'h5);
      rd(`DOTC_ADDR_IRQ_ST, 32'h2);
      wr(`DOTC_ADDR_RELAY, 32'h1);
      chk({16'h0, relay}, 32'h1);
      out_is(8'h1, 32'h0);
      wr(`DOTC_ADDR_CMD, 32'h4);
      wait_apply;
      out_is(8'h1, v);
      out_is(8'h2, v2);
      // Interrupt raised, masked, cleared
      rd(`DOTC_ADDR_IRQ_ST, 32'h3);
      chk({31'h0, irq}, 32'h0);
      wr(`DOTC_ADDR_IRQ_MSK, 32'h1);
      @(posedge core_clk_i);
      chk({31'h0, irq}, 32'h1);
      wr(`DOTC_ADDR_IRQ_ST, 32'h3);
      @(posedge core_clk_i);
      chk({31'h0, irq}, 32'h0);
      // Index range edges
      wr(`DOTC_ADDR_PIDX, 32'h10);
      rd(`DOTC_ADDR_IRQ_ST, 32'h0);
      wr(`DOTC_ADDR_PIDX, 32'h0);
      rd(`DOTC_ADDR_IRQ_ST, 32'h2);
      wr(`DOTC_ADDR_IRQ_ST, 32'h2);
      wr(`DOTC_ADDR_PIDX, 32'h11);
      rd(`DOTC_ADDR_IRQ_ST, 32'h2);
      // Abort, ignored event, then armed again
      wr(`DOTC_ADDR_CMD, 32'h1);
      wr(`DOTC_ADDR_CMD, 32'h2);
      wr(`DOTC_ADDR_CMD, 32'h4);
      rd(`DOTC_ADDR_STATUS, 32'h0);
      wr(`DOTC_ADDR_CMD, 32'h1);
      rd(`DOTC_ADDR_STATUS, 32'h1);
      wr(`DOTC_ADDR_CMD, 32'h2);
      for (int o = 0; o < 4; o++) arm_fire(o[1:0], $urandom_range(7));
      wr(`DOTC_ADDR_CMD, 32'h8);
      rd(`DOTC_ADDR_STATUS, 32'h4);
      // Eight-channel build: index nine is out of range
      sixteen <= 1'h0;
      rd(`DOTC_ADDR_CHCNT, 32'h8);
      wr(`DOTC_ADDR_IRQ_ST, 32'h7);
      wr(`DOTC_ADDR_PIDX, 32'h9);
      rd(`DOTC_ADDR_IRQ_ST, 32'h2);
      chk(n_apply, n_fires);
      complete_run;
   end
endmodule
bind dotc_trigger_ctrl dotc_trigger_ctrl_chk dotc_trigger_ctrl_chk_inst (.*);
